// ==== dv/counter_pwm_process_control_bench.sv ====
// Purpose: drives the gateway over APB and the counter field inputs
// Assumes: each access ends when pready is high
// Notes: a monitor compares every access with a queued note
`timescale 1ns/10ps
module counter_pwm_process_control_bench;
  logic clock;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pulse_output;
  logic [31:0] pwdata = 32'h0, prdata, ld, seed = 32'h24, ctl = 32'h0;
  logic count_pulse_input = 1'b0, count_direction_input = 1'b0, gate_auxiliary_input = 1'b0;
  logic [64:0] e;
  logic [64:0] exp_q[$];
  int fails = 0, tests_run = 0, hi;
  cpp_if cpp_if_i ();
  cpp_gateway cpp_gateway_i (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pd(cpp_if_i));
  cpp_device cpp_device_i (.clock(clock), .rst(rst), .pd(cpp_if_i),
    .count_pulse_input(count_pulse_input), .count_direction_input(count_direction_input),
    .gate_auxiliary_input(gate_auxiliary_input), .pulse_output(pulse_output));
  cpp_asserts cpp_asserts_i (.clock(clock), .rst(rst), .out_image(cpp_if_i.out_image),
    .in_image(cpp_if_i.in_image), .param(cpp_if_i.param));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [32:0] x, input logic [32:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t exp %h got %h", $time, x, g);
    end
  endtask
  // One APB access, entered just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [64:0] x);
    exp_q.push_back(x);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 65'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    repeat (4) @(posedge clock);
    apb(a, 1'b0, 32'h0, {1'b0, m, v});
  endtask
  task automatic ctlw(input logic [31:0] d);
    ctl = d;
    wr(12'h000, d);
  endtask
  // Register write through slot zero and its strobe
  task automatic regw(input logic [7:0] n, input logic [31:0] v);
    wr(12'h004, {n, n, 16'h0000});
    wr(12'h008, v);
    wr(12'h000, ctl | 32'h100);
    wr(12'h000, ctl);
  endtask
  task automatic pulses(input int n, input logic dn);
    count_direction_input <= dn;
    repeat (n) begin
      repeat (2) @(posedge clock);
      count_pulse_input <= 1'b1;
      repeat (2) @(posedge clock);
      count_pulse_input <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask
  task automatic pcount(input int w, input int n, input int x);
    hi = 0;
    repeat (w) @(posedge clock);
    repeat (n) begin
      @(negedge clock);
      hi += (pulse_output === 1'b1);
    end
    @(posedge clock);
    chk(33'(x), 33'(hi));
  endtask
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Monitor: oldest note against each finished access
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      chk({e[64], e[31:0]}, {pslverr, prdata & e[63:32]});
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(12'h040, 32'h7, 32'h1); // Counter on
    rd(12'h044, 32'h30, 32'h10); // Pulse on
    apb(12'h060, 1'b0, 32'h0, {1'b1, 64'h0}); // Unmapped read refused
    ctlw(32'h1);
    rd(12'h040, 32'h7, 32'h0); // Counter off
    ctlw(32'h0);
    seed = xs(seed);
    ld = seed;
    regw(8'h23, ld);
    rd(12'h048, 32'hFFFF_FFFF, ld); // Direct slot
    ctlw(32'h4);
    rd(12'h040, 32'h4, 32'h4); // Acknowledge
    rd(12'h04C, 32'hFFFF_FFFF, ld); // Load copied
    ctlw(32'h2);
    rd(12'h040, 32'h7, 32'h3); // Soft gate
    pulses(5, 1'b0);
    pulses(2, 1'b1);
    rd(12'h04C, 32'hFFFF_FFFF, ld + 32'h3); // Up and down
    ctlw(32'h0);
    gate_auxiliary_input <= 1'b1;
    pulses(1, 1'b0);
    rd(12'h040, 32'h7, 32'h3); // Hardware gate
    ctlw(32'h1);
    pulses(2, 1'b0);
    rd(12'h04C, 32'hFFFF_FFFF, ld + 32'h4); // Held while off
    ctlw(32'h0);
    gate_auxiliary_input <= 1'b0;
    regw(8'h60, 32'h4);
    regw(8'h61, 32'h2);
    ctlw(32'h2_0000);
    pcount(4, 16, 8); // Period and duty
    rd(12'h044, 32'h30, 32'h30); // Pulse running
    ctlw(32'h0);
    regw(8'h64, 32'h3);
    ctlw(32'h6_0000);
    pcount(0, 40, 6); // Finite burst
    rd(12'h044, 32'h30, 32'h10); // Burst over
    ctlw(32'h3_0000);
    rd(12'h044, 32'h30, 32'h0); // Pulse off
    pcount(0, 8, 0); // Silent while off
    ctlw(32'h0);
    wr(12'h020, 32'h0080_0000);
    gate_auxiliary_input <= 1'b1;
    rd(12'h044, 32'h30, 32'h30); // Pulse hardware gate
    rd(12'h040, 32'h7, 32'h1); // Counter not gated
    print_verdict();
  end
endmodule

// ==== dv/cpp_asserts.sv ====
// Purpose: checks on the process image between gateway and device
// Assumes: one clock, synchronous active-high reset
// Notes: status checks except pwm_run_a start three clocks after reset
`timescale 1ns/10ps
module cpp_asserts (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [191:0] out_image, // Gateway to device
  input wire logic [191:0] in_image, // Device to gateway
  input wire logic [127:0] param // Parameter image
);
  logic [1:0] up_reg; // Clocks since reset
  logic live; // Status settled
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Count clocks after reset
  always_ff @(posedge clock) begin
    if (rst)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  assign live = up_reg == 2'h3;
  // Global flags follow the off bits one clock later
  cnt_on_a: assert property (live |-> in_image[0] == !$past(out_image[0]))
    else $error("counter on flag wrong");
  pwm_on_a: assert property (live |-> in_image[36] == !$past(out_image[16]))
    else $error("pulse on flag wrong");
  // Counter running needs a gate and the channel on; pulse running needs the channel on
  cnt_gate_a:
    assert property (live && !$past(out_image[1]) && $past(param[23:20]) != 4'h1
      |-> !in_image[1]) else $error("counter runs ungated");
  cnt_off_a: assert property (live && $past(out_image[0]) |-> !in_image[1])
    else $error("counter runs while off");
  pwm_off_a: assert property (live && $past(out_image[16]) |-> !in_image[37])
    else $error("pulse runs while off");
  pwm_run_a: assert property (in_image[37] |-> in_image[36])
    else $error("pulse run without on");
  // Reload acknowledge follows the request edges
  ack_set_a: assert property (live && $rose(out_image[2]) |-> ##[1:2] in_image[2])
    else $error("reload not acknowledged");
  ack_clr_a: assert property (live && $fell(out_image[2]) |-> ##[1:2] !in_image[2])
    else $error("acknowledge stuck");
  cover property (live && $rose(in_image[2]));
  cover property (live && in_image[1]);
  cover property (live && in_image[37]);
endmodule

// ==== logic/cpp_device.sv ====
// Purpose: counter channel one, pulse channel one and 128-word register file
// Assumes: field inputs synchronous to clock; process image from cpp_if
// Notes: mapped read values lag the register file by one clock
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module cpp_device (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  cpp_if.dev pd, // Process image
  input wire logic count_pulse_input, // Count pulses
  input wire logic count_direction_input, // Direction level, high counts down
  input wire logic gate_auxiliary_input, // Hardware gate
  output logic pulse_output // Pulse train
);
  parameter logic [31:0] HW_VERSION = 32'h0000_0001; // Arbitrary value

  // Process output image layout
  //   Byte 0: counter off, soft gate, soft reload request
  //   Byte 1: rising-edge write strobes, one per slot
  //   Byte 2: pulse off, soft gate, finite burst
  //   Byte 6: direct write register number
  //   Byte 7: direct read register number
  //   Bytes 8-23: write data, one word per slot
  // Process input image layout
  //   Byte 0: counter on, running, reload acknowledge
  //   Byte 4: pulse on in bit 4, running in bit 5
  //   Bytes 8-23: read data, one word per slot
  // Parameter image use
  //   Byte 2: counting scheme low, auxiliary function high
  //   Bytes 10-12: read numbers for slots 1-3
  //   Bytes 13-15: write numbers for slots 1-3
  // Limitations
  //   Schemes other than pulse/direction hold the count
  //   Period zero keeps the pulse output low
  //   Burst needs the gate reopened to reload

  // Whole module state, registered in one place
  typedef struct packed {
    // Register file, one word per number
    logic [127:0][31:0] regs;
    // Edge detectors for count input, reload and strobes
    logic a_prev;
    logic reload_prev;
    logic [3:0] wr_prev;
    // Reload acknowledge, held until request drops
    logic ack;
    // Pulse generator: gate history, phase, bursts left
    logic pwm_prev;
    logic [31:0] phase;
    logic [31:0] left;
    logic pulse;
    // Registered process input image
    logic [191:0] in_img;
  } cpp_dev_state_t;

  cpp_dev_state_t q;
  cpp_dev_state_t s;
  logic [191:0] out_w;
  logic [127:0] par_w;
  logic [3:0] scheme;
  logic [3:0] aux_fn;
  logic cnt_on;
  logic cnt_gate;
  logic pwm_on;
  logic pwm_gate;
  logic pwm_run;
  logic [6:0] num;

  assign out_w = pd.out_image;
  assign par_w = pd.param;
  assign scheme = par_w[cpp_pkg::PB_SCHEME +: 4];
  assign aux_fn = par_w[cpp_pkg::PB_AUX +: 4];

  // Register read mux with fixed-content registers
  function automatic logic [31:0] rd(input logic [6:0] n, input cpp_dev_state_t st,
                                     input logic [127:0] par);
    case (n)
      cpp_pkg::REG_HW_VERSION: rd = HW_VERSION;
      cpp_pkg::REG_CONFIG_ERROR: rd = 32'h0000_0000;
      cpp_pkg::REG_INPUT_WORD_ONE: rd = st.in_img[31:0];
      cpp_pkg::REG_PARAM_WORD_ONE: rd = par[31:0];
      default: rd = st.regs[n];
    endcase
  endfunction

  // Gate terms for both channels
  always_comb begin
    cnt_on = !out_w[cpp_pkg::OB_CNT_OFF];
    cnt_gate = cnt_on && (out_w[cpp_pkg::OB_CNT_GATE]
      || (aux_fn == cpp_pkg::AUX_GATE_CNT && gate_auxiliary_input));
    pwm_on = !out_w[cpp_pkg::OB_PWM_OFF];
    pwm_gate = pwm_on && (out_w[cpp_pkg::OB_PWM_GATE]
      || (aux_fn == cpp_pkg::AUX_GATE_PWM && gate_auxiliary_input));
    pwm_run = pwm_gate && q.pwm_prev && q.regs[cpp_pkg::REG_PWM_PERIOD] != 32'h0000_0000
      && (!out_w[cpp_pkg::OB_PWM_BURST] || q.left != 32'h0000_0000);
  end

  // Next-state logic
  always_comb begin
    s = q;
    num = 7'h00;
    // Counting on rising A edges in pulse/direction scheme
    if (cnt_gate && scheme == cpp_pkg::SCHEME_PULSE_DIR && count_pulse_input && !q.a_prev) begin
      if (count_direction_input) begin
        s.regs[cpp_pkg::REG_CNT_VALUE] = q.regs[cpp_pkg::REG_CNT_VALUE] - 32'h0000_0001;
      end else begin
        s.regs[cpp_pkg::REG_CNT_VALUE] = q.regs[cpp_pkg::REG_CNT_VALUE] + 32'h0000_0001;
      end
    end
    s.a_prev = count_pulse_input;
    // Latch-retrigger on request edge; ack held until request drops
    // Reload placed after counting so it wins the same clock
    // Request must fall before another reload is taken
    s.reload_prev = out_w[cpp_pkg::OB_CNT_RELOAD];
    if (out_w[cpp_pkg::OB_CNT_RELOAD] && !q.reload_prev) begin
      s.regs[cpp_pkg::REG_CNT_VALUE] = q.regs[cpp_pkg::REG_CNT_LOAD];
      s.ack = 1'b1;
    end else if (!out_w[cpp_pkg::OB_CNT_RELOAD]) begin
      s.ack = 1'b0;
    end
    // Mapped writes on rising strobe of each slot
    // Slot zero numbered from the output image, others from parameters
    // A mapped write overrides count and reload in the same clock
    for (int k = 0; k < cpp_pkg::SLOTS; k++) begin
      if (k == 0) begin
        num = out_w[cpp_pkg::OB_WR_NUM +: 7];
      end else begin
        num = par_w[cpp_pkg::PB_WR_NUM + 8 * (k - 1) +: 7];
      end
      if (out_w[cpp_pkg::OB_WR_STB + k] && !q.wr_prev[k]) begin
        s.regs[num] = out_w[cpp_pkg::OB_DATA + 32 * k +: 32];
      end
    end
    s.wr_prev = out_w[cpp_pkg::OB_WR_STB +: 4];
    // Pulse generator: burst count loaded when gate opens
    // First pulse starts one clock after the load
    s.pwm_prev = pwm_gate;
    if (pwm_gate && !q.pwm_prev) begin
      s.phase = 32'h0000_0000;
      s.left = q.regs[cpp_pkg::REG_PWM_COUNT_LOAD];
    end
    if (pwm_run) begin
      s.pulse = q.phase < q.regs[cpp_pkg::REG_PWM_DUTY];
      if (q.phase >= q.regs[cpp_pkg::REG_PWM_PERIOD] - 32'h0000_0001) begin
        s.phase = 32'h0000_0000;
        if (out_w[cpp_pkg::OB_PWM_BURST]) begin
          s.left = q.left - 32'h0000_0001;
        end
      end else begin
        s.phase = q.phase + 32'h0000_0001;
      end
    end else begin
      s.pulse = 1'b0;
    end
    // Process input image: status bits and mapped reads
    // Mapped values lag the register file by one clock
    s.in_img = '0;
    s.in_img[cpp_pkg::IB_CNT_ON] = cnt_on;
    s.in_img[cpp_pkg::IB_CNT_RUN] = cnt_gate;
    s.in_img[cpp_pkg::IB_CNT_ACK] = q.ack;
    s.in_img[cpp_pkg::IB_PWM_ON] = pwm_on;
    s.in_img[cpp_pkg::IB_PWM_RUN] = pwm_run;
    for (int k = 0; k < cpp_pkg::SLOTS; k++) begin
      if (k == 0) begin
        num = out_w[cpp_pkg::OB_RD_NUM +: 7];
      end else begin
        num = par_w[cpp_pkg::PB_RD_NUM + 8 * (k - 1) +: 7];
      end
      s.in_img[cpp_pkg::IB_DATA + 32 * k +: 32] = rd(num, q, par_w);
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign pd.in_image = q.in_img;
  assign pulse_output = q.pulse;
endmodule

// ==== logic/cpp_gateway.sv ====
// Purpose: gateway end; APB registers drive output and parameter images
// Assumes: APB3 master on the same clock
// Notes: one wait-free access phase; reads captured in setup
`timescale 1ns/10ps
module cpp_gateway (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  cpp_if.gw pd // Process image
);
  typedef struct packed {
    logic [5:0][31:0] out_w;
    logic [3:0][31:0] par_w;
    logic [31:0] rdata;
    logic err;
  } cpp_gw_state_t;

  cpp_gw_state_t q;
  cpp_gw_state_t s;
  logic [2:0] word;
  logic aligned;
  logic hit_out;
  logic hit_par;
  logic hit_in;

  // Address decode
  always_comb begin
    word = paddr[4:2];
    aligned = paddr[1:0] == 2'b00;
    hit_out = aligned && paddr[11:5] == cpp_pkg::ADDR_OUT[11:5] && word < cpp_pkg::OUT_WORDS;
    hit_par = aligned && paddr[11:5] == cpp_pkg::ADDR_PAR[11:5] && word < cpp_pkg::PAR_WORDS;
    hit_in = aligned && paddr[11:5] == cpp_pkg::ADDR_IN[11:5] && word < cpp_pkg::OUT_WORDS;
  end

  // Setup captures read data and error; access commits writes
  always_comb begin
    s = q;
    if (psel && !penable) begin
      s.rdata = 32'h0000_0000;
      s.err = !(hit_out || hit_par || (hit_in && !pwrite));
      if (!pwrite) begin
        if (hit_out) begin
          s.rdata = q.out_w[word];
        end else if (hit_par) begin
          s.rdata = q.par_w[word];
        end else if (hit_in) begin
          s.rdata = pd.in_image[32 * word +: 32];
        end
      end
    end
    if (psel && penable && pwrite) begin
      if (hit_out) begin
        s.out_w[word] = pwdata;
      end else if (hit_par) begin
        s.par_w[word] = pwdata;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.par_w <= cpp_pkg::PAR_RESET;
    end else begin
      q <= s;
    end
  end

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = q.err && psel && penable;
  assign pd.out_image = q.out_w;
  assign pd.param = q.par_w;
endmodule

// ==== logic/cpp_if.sv ====
// Purpose: cyclic process image between gateway and counter/pulse device
// Assumes: both ends on the same clock
// Notes: plain wires, no clocking
`timescale 1ns/10ps
interface cpp_if;
  logic [191:0] out_image;
  logic [191:0] in_image;
  logic [127:0] param;
  modport dev (input out_image, input param, output in_image);
  modport gw (output out_image, output param, input in_image);
endinterface

// ==== logic/cpp_pkg.sv ====
// Purpose: shared constants for the counter/pulse process-image pair
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: bit positions count from bit 0 of byte 0 of each image
package cpp_pkg;
  localparam int IMG_BITS = 192;
  localparam int PAR_BITS = 128;
  localparam int NREG = 128;
  localparam int SLOTS = 4;
  // Process output image (gateway to device)
  localparam int OB_CNT_OFF = 0;
  localparam int OB_CNT_GATE = 1;
  localparam int OB_CNT_RELOAD = 2;
  localparam int OB_WR_STB = 8;
  localparam int OB_PWM_OFF = 16;
  localparam int OB_PWM_GATE = 17;
  localparam int OB_PWM_BURST = 18;
  localparam int OB_WR_NUM = 48;
  localparam int OB_RD_NUM = 56;
  localparam int OB_DATA = 64;
  // Process input image (device to gateway)
  localparam int IB_CNT_ON = 0;
  localparam int IB_CNT_RUN = 1;
  localparam int IB_CNT_ACK = 2;
  localparam int IB_PWM_ON = 36;
  localparam int IB_PWM_RUN = 37;
  localparam int IB_DATA = 64;
  // Parameter image
  localparam int PB_SCHEME = 16;
  localparam int PB_AUX = 20;
  localparam int PB_RD_NUM = 80;
  localparam int PB_WR_NUM = 104;
  localparam logic [127:0] PAR_RESET = 128'h4021_2070_6120_0000_0000_0000_0010_0000;
  // Register numbers
  localparam logic [6:0] REG_HW_VERSION = 7'h02;
  localparam logic [6:0] REG_CONFIG_ERROR = 7'h0A;
  localparam logic [6:0] REG_INPUT_WORD_ONE = 7'h0C;
  localparam logic [6:0] REG_PARAM_WORD_ONE = 7'h1C;
  localparam logic [6:0] REG_CNT_VALUE = 7'h20;
  localparam logic [6:0] REG_CNT_LOAD = 7'h23;
  localparam logic [6:0] REG_PWM_PERIOD = 7'h60;
  localparam logic [6:0] REG_PWM_DUTY = 7'h61;
  localparam logic [6:0] REG_PWM_COUNT_LOAD = 7'h64;
  // Modes
  localparam logic [3:0] SCHEME_PULSE_DIR = 4'h0;
  localparam logic [3:0] AUX_GATE_CNT = 4'h1;
  localparam logic [3:0] AUX_GATE_PWM = 4'h8;
  // APB map of the gateway end
  localparam logic [11:0] ADDR_OUT = 12'h000;
  localparam logic [11:0] ADDR_PAR = 12'h020;
  localparam logic [11:0] ADDR_IN = 12'h040;
  localparam logic [2:0] OUT_WORDS = 3'h6;
  localparam logic [2:0] PAR_WORDS = 3'h4;
endpackage
